// file: include/hfh_pkg.sv
// shared constants and pointer helpers for the hardened fifo
package hfh_pkg;
    // -------------------------------------------------------------------
    // geometry
    // -------------------------------------------------------------------
    localparam int DATA_W_DEF = 18;
    localparam int ADDR_W_DEF = 10;
    localparam int CAP_BITS = 18432;
    localparam int PTR_MAX_W = 11;

    // -------------------------------------------------------------------
    // register map
    // -------------------------------------------------------------------
    localparam int BUS_AW = 8;
    localparam int BUS_DW = 32;
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_FLAGS = 8'h08;
    localparam logic [7:0] REG_CTRL = 8'h0c;
    localparam int EV_W = 2;
    localparam int EV_OVF = 0;
    localparam int EV_UDF = 1;
    localparam int FLG_FULL = 0;
    localparam int FLG_AFULL = 1;
    localparam int CTRL_CLR = 0;
    localparam logic [1:0] EV_RST = 2'h0;

    // -------------------------------------------------------------------
    // gray helpers
    // -------------------------------------------------------------------
    function automatic logic [PTR_MAX_W-1:0] bin2gray(input logic [PTR_MAX_W-1:0] b);
        bin2gray = b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [PTR_MAX_W-1:0] gray2bin(input logic [PTR_MAX_W-1:0] g);
        logic [PTR_MAX_W-1:0] b;
        b = '0;
        for (int i = PTR_MAX_W - 1; i >= 0; i--)
        begin
            b[i] = g[i] ^ ((i == PTR_MAX_W - 1) ? 1'b0 : b[i+1]);
        end
        gray2bin = b;
    endfunction : gray2bin
endpackage : hfh_pkg

// file: hw/hfh_sync.sv
// two-stage synchroniser, or a plain wire when both sides share one clock
`timescale 1ns/10ps
`default_nettype none
module hfh_sync #(
    parameter int W = 1,
    parameter bit BYPASS = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    generate
        if (BYPASS)
        begin : g_wire
            assign o_q = i_d;
        end
        else
        begin : g_ff
            logic [W-1:0] s1_q;
            logic [W-1:0] s2_q;
            logic [W-1:0] s1_d;
            logic [W-1:0] s2_d;
            always_comb
            begin
                s1_d = i_rst ? '0 : i_d;
                s2_d = i_rst ? '0 : s1_q;
            end
            always_ff @(posedge i_clk)
            begin
                s1_q <= s1_d;
                s2_q <= s2_d;
            end
            assign o_q = s2_q;
        end
    endgenerate
endmodule : hfh_sync
`default_nettype wire

// file: hw/hfh_mem.sv
// dual-port storage array with registered read data
`timescale 1ns/10ps
`default_nettype none
module hfh_mem #(
    parameter int DATA_W = 18,
    parameter int ADDR_W = 10
) (
    input wire logic i_wclk,
    input wire logic i_we,
    input wire logic [ADDR_W-1:0] i_waddr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_rclk,
    input wire logic i_rst_rd,
    input wire logic i_re,
    input wire logic [ADDR_W-1:0] i_raddr,
    output logic [DATA_W-1:0] o_rdata
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [DATA_W-1:0] rdata_q;

    always_ff @(posedge i_wclk)
    begin
        if (i_we)
        begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_rclk)
    begin
        if (i_rst_rd)
        begin
            rdata_q <= '0;
        end
        else if (i_re)
        begin
            rdata_q <= mem[i_raddr];
        end
    end

    assign o_rdata = rdata_q;
endmodule : hfh_mem
`default_nettype wire

// file: hw/hfh_fifo.sv
// hardened fifo with full/empty, near flags, handshake and register port
// Operation
// - overflow flag one cycle after refused write
// - underflow flag one cycle after refused read
// - single clock: same handshake, one domain
// - width up to 18, depth up to 1K
// - width times depth at most 18Kbits
// - shared clock or separate read clock
// - full in write domain, empty in read
// - clear resets both pointers, the read one some cycles later when dual-clock
// - near flags use one fixed threshold each
// - handshake outputs report previous cycle request
// - refused request changes no state
// - full drops write data, empty returns nothing
// - no occupancy count outputs
// - write accept pulses when word stored
// - read accept pulses when word delivered
// - near-empty while count at most threshold
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module hfh_fifo #(
    parameter int DATA_W = hfh_pkg::DATA_W_DEF,
    parameter int ADDR_W = hfh_pkg::ADDR_W_DEF,
    parameter bit DUAL_CLK = 1'b1,
    parameter int AFULL_TH = 1000,
    parameter int AEMPTY_TH = 4
) (
    input wire logic i_clk_sys,
    input wire logic i_clk_rd,
    input wire logic i_rst,
    input wire logic i_clr,
    input wire logic i_wr_en,
    input wire logic [DATA_W-1:0] i_wr_data,
    output logic o_full,
    output logic o_afull,
    output logic o_wr_ack,
    output logic o_overflow,
    input wire logic i_rd_en,
    output logic [DATA_W-1:0] o_rd_data,
    output logic o_empty,
    output logic o_aempty,
    output logic o_rd_ack,
    output logic o_underflow,
    input wire logic [hfh_pkg::BUS_AW-1:0] i_addr,
    input wire logic [hfh_pkg::BUS_DW-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [hfh_pkg::BUS_DW-1:0] o_rdata,
    output logic o_irq
);
    localparam int PW = ADDR_W + 1;
    localparam int PM = hfh_pkg::PTR_MAX_W;
    localparam logic [PW-1:0] P_ONE = PW'(1);
    localparam logic [PW-1:0] AFULL_LIM = PW'(AFULL_TH);
    localparam logic [PW-1:0] AEMPTY_LIM = PW'(AEMPTY_TH);

    // -------------------------------------------------------------------
    // read clock selection
    // -------------------------------------------------------------------
    logic rclk;
    logic rrst;
    logic rclr;
    logic clr_w;
    logic clrt_q, clrt_d, clrt_s, clrt_h_q, clrt_h_d;
    logic [PM-1:0] wg_full, wr_bin, rg_full, rw_bin;
    assign rclk = DUAL_CLK ? i_clk_rd : i_clk_sys;

    hfh_sync #(.W(1), .BYPASS(!DUAL_CLK)) u_rst_sync (
        .i_clk(rclk),
        .i_rst(1'b0),
        .i_d(i_rst),
        .o_q(rrst)
    );
    hfh_sync #(.W(1), .BYPASS(!DUAL_CLK)) u_clr_sync (
        .i_clk(rclk),
        .i_rst(rrst),
        .i_d(clrt_q),
        .o_q(clrt_s)
    );

    // -------------------------------------------------------------------
    // write domain
    // -------------------------------------------------------------------
    logic [PW-1:0] wbin_q, wbin_d, wgray_q, wgray_d, rgray_w, wcnt;
    logic [PW-1:0] rgray_q, rgray_d, rbin_q, rbin_d, wgray_r, rcnt;
    logic full_q, full_d, afull_q, afull_d, wack_q, wack_d, ovf_q, ovf_d;
    logic wr_ok;

    hfh_sync #(.W(PW), .BYPASS(!DUAL_CLK)) u_rptr_sync (
        .i_clk(i_clk_sys),
        .i_rst(i_rst),
        .i_d(rgray_q),
        .o_q(rgray_w)
    );

    always_comb
    begin
        wr_ok = i_wr_en && !full_q && !clr_w;
        wbin_d = clr_w ? '0 : (wr_ok ? wbin_q + P_ONE : wbin_q);
        wg_full = hfh_pkg::bin2gray(PM'(wbin_d));
        wgray_d = wg_full[PW-1:0];
        full_d = (wgray_d == {~rgray_w[PW-1:PW-2], rgray_w[PW-3:0]});
        wr_bin = hfh_pkg::gray2bin(PM'(rgray_w));
        wcnt = wbin_d - wr_bin[PW-1:0];
        afull_d = (wcnt >= AFULL_LIM);
        wack_d = wr_ok;
        ovf_d = i_wr_en && full_q && !clr_w;
        // clear crosses as a toggle so a one-cycle pulse is never lost
        clrt_d = clrt_q ^ clr_w;
        // far pointer is stale during a clear: flags follow the empty buffer
        if (clr_w)
        begin
            full_d = 1'b0;
            afull_d = (AFULL_LIM == '0);
        end
        if (i_rst)
        begin
            clrt_d = 1'b0;
            wbin_d = '0;
            wgray_d = '0;
            full_d = 1'b0;
            afull_d = 1'b0;
            wack_d = 1'b0;
            ovf_d = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        wbin_q <= wbin_d;
        wgray_q <= wgray_d;
        full_q <= full_d;
        afull_q <= afull_d;
        wack_q <= wack_d;
        ovf_q <= ovf_d;
        clrt_q <= clrt_d;
    end

    // -------------------------------------------------------------------
    // read domain
    // -------------------------------------------------------------------
    logic empty_q, empty_d, aempty_q, aempty_d, rack_q, rack_d, udf_q, udf_d;
    logic udft_q, udft_d, rd_ok;

    hfh_sync #(.W(PW), .BYPASS(!DUAL_CLK)) u_wptr_sync (
        .i_clk(rclk),
        .i_rst(rrst),
        .i_d(wgray_q),
        .o_q(wgray_r)
    );

    always_comb
    begin
        rclr = DUAL_CLK ? (clrt_s ^ clrt_h_q) : clr_w;
        clrt_h_d = clrt_s;
        rd_ok = i_rd_en && !empty_q && !rclr;
        rbin_d = rclr ? '0 : (rd_ok ? rbin_q + P_ONE : rbin_q);
        rg_full = hfh_pkg::bin2gray(PM'(rbin_d));
        rgray_d = rg_full[PW-1:0];
        empty_d = (rgray_d == wgray_r);
        rw_bin = hfh_pkg::gray2bin(PM'(wgray_r));
        rcnt = rw_bin[PW-1:0] - rbin_d;
        aempty_d = (rcnt <= AEMPTY_LIM);
        rack_d = rd_ok;
        udf_d = i_rd_en && empty_q && !rclr;
        udft_d = udft_q ^ udf_d;
        // no false data while the far pointer still shows the old fill
        if (rclr)
        begin
            empty_d = 1'b1;
            aempty_d = 1'b1;
        end
        if (rrst)
        begin
            rbin_d = '0;
            rgray_d = '0;
            empty_d = 1'b1;
            aempty_d = 1'b1;
            rack_d = 1'b0;
            udf_d = 1'b0;
            udft_d = 1'b0;
            clrt_h_d = 1'b0;
        end
    end

    always_ff @(posedge rclk)
    begin
        rbin_q <= rbin_d;
        rgray_q <= rgray_d;
        empty_q <= empty_d;
        aempty_q <= aempty_d;
        rack_q <= rack_d;
        udf_q <= udf_d;
        udft_q <= udft_d;
        clrt_h_q <= clrt_h_d;
    end

    hfh_mem #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_mem (
        .i_wclk(i_clk_sys),
        .i_we(wr_ok),
        .i_waddr(wbin_q[ADDR_W-1:0]),
        .i_wdata(i_wr_data),
        .i_rclk(rclk),
        .i_rst_rd(rrst),
        .i_re(rd_ok),
        .i_raddr(rbin_q[ADDR_W-1:0]),
        .o_rdata(o_rd_data)
    );

    // -------------------------------------------------------------------
    // register port and interrupt
    // -------------------------------------------------------------------
    logic udft_s, udft_h_q, udft_h_d, sclr_q, sclr_d, irq_q, irq_d;
    logic [hfh_pkg::EV_W-1:0] st_q, st_d, mask_q, mask_d, ev;
    logic [hfh_pkg::BUS_DW-1:0] rdata_q, rdata_d;

    hfh_sync #(.W(1), .BYPASS(!DUAL_CLK)) u_udf_sync (
        .i_clk(i_clk_sys),
        .i_rst(i_rst),
        .i_d(udft_q),
        .o_q(udft_s)
    );

    assign clr_w = i_clr | sclr_q;

    always_comb
    begin
        ev = '0;
        ev[hfh_pkg::EV_OVF] = ovf_q;
        ev[hfh_pkg::EV_UDF] = udft_s ^ udft_h_q;
        udft_h_d = udft_s;
        st_d = st_q;
        mask_d = mask_q;
        sclr_d = 1'b0;
        rdata_d = '0;
        if (i_wr && i_addr == hfh_pkg::REG_STATUS)
        begin
            st_d = st_q & ~i_wdata[hfh_pkg::EV_W-1:0];
        end
        st_d = st_d | ev;
        if (i_wr && i_addr == hfh_pkg::REG_MASK)
        begin
            mask_d = i_wdata[hfh_pkg::EV_W-1:0];
        end
        if (i_wr && i_addr == hfh_pkg::REG_CTRL)
        begin
            sclr_d = i_wdata[hfh_pkg::CTRL_CLR];
        end
        if (i_rd)
        begin
            case (i_addr)
                hfh_pkg::REG_STATUS: rdata_d[hfh_pkg::EV_W-1:0] = st_q;
                hfh_pkg::REG_MASK: rdata_d[hfh_pkg::EV_W-1:0] = mask_q;
                hfh_pkg::REG_FLAGS:
                begin
                    rdata_d[hfh_pkg::FLG_FULL] = full_q;
                    rdata_d[hfh_pkg::FLG_AFULL] = afull_q;
                end
                default: rdata_d = '0;
            endcase
        end
        irq_d = |(st_q & mask_q);
        if (i_rst)
        begin
            st_d = hfh_pkg::EV_RST;
            mask_d = hfh_pkg::EV_RST;
            sclr_d = 1'b0;
            rdata_d = '0;
            irq_d = 1'b0;
            udft_h_d = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        st_q <= st_d;
        mask_q <= mask_d;
        sclr_q <= sclr_d;
        rdata_q <= rdata_d;
        irq_q <= irq_d;
        udft_h_q <= udft_h_d;
    end

    // -------------------------------------------------------------------
    // outputs (no occupancy count is exported)
    // -------------------------------------------------------------------
    assign o_full = full_q;
    assign o_afull = afull_q;
    assign o_wr_ack = wack_q;
    assign o_overflow = ovf_q;
    assign o_empty = empty_q;
    assign o_aempty = aempty_q;
    assign o_rd_ack = rack_q;
    assign o_underflow = udf_q;
    assign o_rdata = rdata_q;
    assign o_irq = irq_q;

    // -------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------
    a_size_limit:
        assert property (@(posedge i_clk_sys) DATA_W * (1 << ADDR_W) <= hfh_pkg::CAP_BITS)
        else $error("fifo storage exceeds capacity");
    a_geom_limit:
        assert property (@(posedge i_clk_sys) DATA_W <= hfh_pkg::DATA_W_DEF
            && ADDR_W <= hfh_pkg::ADDR_W_DEF)
        else $error("fifo geometry too large");
    a_ovf_after_full:
        assert property (@(posedge i_clk_sys) disable iff (i_rst)
            i_wr_en && o_full && !clr_w |=> o_overflow && !o_wr_ack)
        else $error("refused write not flagged");
    a_udf_after_empty:
        assert property (@(posedge rclk) disable iff (rrst)
            i_rd_en && o_empty && !rclr |=> o_underflow && !o_rd_ack)
        else $error("refused read not flagged");
    a_wack_on_store:
        assert property (@(posedge i_clk_sys) disable iff (i_rst)
            i_wr_en && !o_full && !clr_w |=> o_wr_ack && wbin_q == $past(wbin_q) + P_ONE)
        else $error("accepted write not acknowledged");
    a_rack_on_read:
        assert property (@(posedge rclk) disable iff (rrst)
            i_rd_en && !o_empty && !rclr |=> o_rd_ack && rbin_q == $past(rbin_q) + P_ONE)
        else $error("accepted read not acknowledged");
    a_full_ptr_hold:
        assert property (@(posedge i_clk_sys) disable iff (i_rst)
            o_full && !clr_w |=> $stable(wbin_q))
        else $error("write pointer moved while full");
    a_empty_data_hold:
        assert property (@(posedge rclk) disable iff (rrst)
            o_empty && !rclr |=> $stable(o_rd_data) && $stable(rbin_q))
        else $error("read data changed while empty");
    a_clr_ptrs:
        assert property (@(posedge i_clk_sys) disable iff (i_rst)
            clr_w |=> wbin_q == '0 && (DUAL_CLK || rbin_q == '0))
        else $error("clear did not reset write pointer");
    a_wr_hs_excl:
        assert property (@(posedge i_clk_sys) disable iff (i_rst)
            o_wr_ack || o_overflow |-> !(o_wr_ack && o_overflow) && $past(i_wr_en))
        else $error("write handshake without request");
endmodule : hfh_fifo
`default_nettype wire

// file: verif/hfh_user.sv
// user write and read logic that faces the fifo
`timescale 1ns/10ps
`default_nettype none
module hfh_user #(
    parameter int W = 18
) (
    input wire logic i_clk_sys,
    input wire logic i_push,
    input wire logic i_pop,
    input wire logic i_force,
    input wire logic [W-1:0] i_data,
    input wire logic i_full,
    input wire logic i_empty,
    output logic o_wr_en,
    output logic [W-1:0] o_wr_data,
    output logic o_rd_en
);
    logic [W-1:0] last_q = '0;
    // requests held back on full or empty unless a refusal is wanted
    assign o_wr_en = i_push && (!i_full || i_force);
    assign o_rd_en = i_pop && (!i_empty || i_force);
    // idle data line shows the inverse of the last word
    assign o_wr_data = o_wr_en ? i_data : ~last_q;
    always_ff @(posedge i_clk_sys)
    begin
        if (o_wr_en)
        begin
            last_q <= i_data;
        end
    end
endmodule : hfh_user
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the hardened fifo in single-clock and dual-clock mode
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam int W = 18;
    localparam int D = 16;
    localparam int AF = 14;
    localparam int AE = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic clr = 1'b0;
    logic push = 1'b0;
    logic pop = 1'b0;
    logic frc = 1'b0;
    logic [W-1:0] wd = '0;
    logic [W-1:0] wr_data, rd_data;
    logic wr_en, rd_en, full, afull, wr_ack, ovf, empty, aempty, rd_ack, udf, irq;
    logic [7:0] addr = '0;
    logic [31:0] bwd = '0;
    logic bwr = 1'b0;
    logic brd = 1'b0;
    logic [31:0] brdata;
    logic [W-1:0] q[$];
    logic [W-1:0] last_rd = '0;
    int errors = 0;
    int checks_done = 0;
    int cyc = 0;

    always #4 clk = ~clk;

    hfh_user #(.W(W)) u_user (.i_clk_sys(clk), .i_push(push), .i_pop(pop), .i_force(frc),
        .i_data(wd), .i_full(full), .i_empty(empty), .o_wr_en(wr_en),
        .o_wr_data(wr_data), .o_rd_en(rd_en));

    hfh_fifo #(.DATA_W(W), .ADDR_W(4), .DUAL_CLK(1'b0), .AFULL_TH(AF), .AEMPTY_TH(AE)) dut (
        .i_clk_sys(clk), .i_clk_rd(clk), .i_rst(rst), .i_clr(clr), .i_wr_en(wr_en),
        .i_wr_data(wr_data), .o_full(full), .o_afull(afull), .o_wr_ack(wr_ack),
        .o_overflow(ovf), .i_rd_en(rd_en), .o_rd_data(rd_data), .o_empty(empty),
        .o_aempty(aempty), .o_rd_ack(rd_ack), .o_underflow(udf), .i_addr(addr),
        .i_wdata(bwd), .i_wr(bwr), .i_rd(brd), .o_rdata(brdata), .o_irq(irq));

    // second copy with its own read clock
    logic clk_rd = 1'b0;
    logic dc_wr_en = 1'b0;
    logic dc_rd_en = 1'b0;
    logic [W-1:0] dc_wd = '0;
    logic [W-1:0] dc_rd_data;
    logic dc_full, dc_empty, dc_wr_ack, dc_rd_ack;

    always #5 clk_rd = ~clk_rd;

    hfh_fifo #(.DATA_W(W), .ADDR_W(4), .DUAL_CLK(1'b1), .AFULL_TH(AF), .AEMPTY_TH(AE)) dut_dc (
        .i_clk_sys(clk), .i_clk_rd(clk_rd), .i_rst(rst), .i_clr(1'b0), .i_wr_en(dc_wr_en),
        .i_wr_data(dc_wd), .o_full(dc_full), .o_afull(), .o_wr_ack(dc_wr_ack),
        .o_overflow(), .i_rd_en(dc_rd_en), .o_rd_data(dc_rd_data), .o_empty(dc_empty),
        .o_aempty(), .o_rd_ack(dc_rd_ack), .o_underflow(), .i_addr(8'h00),
        .i_wdata(32'h0), .i_wr(1'b0), .i_rd(1'b0), .o_rdata(), .o_irq());

    // ------------------------------------------------------------------
    // checks and bus cycles
    // ------------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            end_of_test();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic chk_flags();
        chk("full", q.size() == D, full);
        chk("empty", q.size() == 0, empty);
        chk("afull", q.size() >= AF, afull);
        chk("aempty", q.size() <= AE, aempty);
    endtask : chk_flags

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        bwd <= d;
        bwr <= 1'b1;
        @(posedge clk);
        bwr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        brd <= 1'b1;
        @(posedge clk);
        brd <= 1'b0;
        #1;
        chk("rdata", e, brdata);
    endtask : bus_rd

    task automatic wr(input logic [W-1:0] d, input logic f);
        logic ok;
        ok = q.size() < D;
        @(posedge clk);
        push <= 1'b1;
        wd <= d;
        frc <= f;
        @(posedge clk);
        push <= 1'b0;
        frc <= 1'b0;
        #1;
        chk("wr_ack", ok, wr_ack);
        chk("overflow", !ok, ovf);
        if (ok)
            q.push_back(d);
        // far-domain flags follow one cycle after the pointer moves
        @(posedge clk);
        #1;
        chk_flags();
    endtask : wr

    task automatic rd(input logic f);
        logic ok;
        ok = q.size() > 0;
        @(posedge clk);
        pop <= 1'b1;
        frc <= f;
        @(posedge clk);
        pop <= 1'b0;
        frc <= 1'b0;
        #1;
        chk("rd_ack", ok, rd_ack);
        chk("underflow", !ok, udf);
        if (ok)
            last_rd = q.pop_front();
        chk("rd_data", last_rd, rd_data);
        @(posedge clk);
        #1;
        chk_flags();
    endtask : rd

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk_flags();
        chk("irq", 0, irq);
        bus_rd(hfh_pkg::REG_FLAGS, 32'h0);
        bus_rd(hfh_pkg::REG_MASK, 32'h0);
    endtask : t_reset

    task automatic t_basic();
        rd(1'b1);
        wr(18'h2aaaa, 1'b0);
        wr(18'h15555, 1'b0);
        rd(1'b0);
        // back to back writes, one ack per cycle
        @(posedge clk);
        push <= 1'b1;
        wd <= 18'h00a01;
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk);
            q.push_back(wd);
            wd <= wd + 18'h00001;
            push <= (i < 2);
            #1;
            chk("wr_ack", 1, wr_ack);
        end
        repeat (4) rd(1'b0);
    endtask : t_basic

    task automatic t_fill();
        for (int i = 0; i < D; i++)
            wr(18'h01000 + 18'(i), 1'b0);
        bus_rd(hfh_pkg::REG_FLAGS, 32'h3);
        wr(18'h3ffff, 1'b1);
        repeat (3) @(posedge clk);
        bus_rd(hfh_pkg::REG_STATUS, 32'h3);
        chk("irq", 0, irq);
        for (int i = 0; i < D; i++)
            rd(1'b0);
        rd(1'b1);
    endtask : t_fill

    task automatic t_clear();
        repeat (3) wr(18'h0beef, 1'b0);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        q.delete();
        chk_flags();
        rd(1'b1);
        repeat (2) wr(18'h0cafe, 1'b0);
        bus_wr(hfh_pkg::REG_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        #1;
        q.delete();
        chk_flags();
        bus_rd(hfh_pkg::REG_CTRL, 32'h0);
    endtask : t_clear

    task automatic t_irq();
        bus_wr(hfh_pkg::REG_STATUS, 32'h3);
        bus_rd(hfh_pkg::REG_STATUS, 32'h0);
        rd(1'b1);
        repeat (3) @(posedge clk);
        bus_rd(hfh_pkg::REG_STATUS, 32'h2);
        chk("irq", 0, irq);
        bus_wr(hfh_pkg::REG_MASK, 32'h3);
        repeat (2) @(posedge clk);
        #1;
        chk("irq", 1, irq);
        bus_rd(hfh_pkg::REG_MASK, 32'h3);
        bus_wr(hfh_pkg::REG_STATUS, 32'h2);
        repeat (2) @(posedge clk);
        #1;
        chk("irq", 0, irq);
        bus_rd(hfh_pkg::REG_STATUS, 32'h0);
        bus_rd(8'h20, 32'h0);
    endtask : t_irq

    task automatic t_dual();
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            dc_wr_en <= 1'b1;
            dc_wd <= 18'h20000 + 18'(i);
        end
        @(posedge clk);
        dc_wr_en <= 1'b0;
        #1;
        chk("dc_wr_ack", 1, dc_wr_ack);
        chk("dc_full", 0, dc_full);
        repeat (6) @(posedge clk_rd);
        #1;
        chk("dc_empty", 0, dc_empty);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_rd);
            dc_rd_en <= 1'b1;
            @(posedge clk_rd);
            dc_rd_en <= 1'b0;
            #1;
            chk("dc_rd_ack", 1, dc_rd_ack);
            chk("dc_rd_data", 18'h20000 + 18'(i), dc_rd_data);
        end
        repeat (6) @(posedge clk_rd);
        #1;
        chk("dc_empty", 1, dc_empty);
        chk("dc_full", 0, dc_full);
    endtask : t_dual

    initial
    begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset();
        t_basic();
        t_fill();
        t_clear();
        t_irq();
        t_dual();
        end_of_test();
    end
endmodule : tb
`default_nettype wire
